// ### rtl/memory_strobe_enable_logic.sv
// strobe and enable generation for memory and peripheral cycles
// assumes bus and cycle timing inputs are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module memory_strobe_enable_logic #(
  parameter int LANE_COUNT = mem_strobe_pkg::LANES
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          powerOnReset_n,
  input  wire mem_strobe_pkg::cpu_bus_t      cpuBus,
  input  wire mem_strobe_pkg::cycle_timing_t cycleTiming,
  input  wire logic                          rawPeriphSelect_n,
  output var  mem_strobe_pkg::strobe_out_t   strobes,
  output var  logic                          periphReadWrite,
  output var  logic                          resetOut_n
);
  import mem_strobe_pkg::*;

  initial begin
    if (LANE_COUNT != LANES) $error("lane count must be four");
  end

  // ----------------------------------------------------------------
  // cycle tracking
  // ----------------------------------------------------------------
  cycle_state_t state;
  cycle_state_t next_state;
  logic         enabled;
  logic         next_enabled;
  logic         latchedWrite;

  wire readReq   = !cpuBus.readStrobe_n;
  wire writeReq  = !cpuBus.writeStrobe_n;
  wire startHit  = !cycleTiming.enableStart_n;
  wire endHit    = !cycleTiming.cycleEnd_n;
  wire inCycle   = (state != IDLE);

  // strobe trailing edges do not end the cycle, only the read transceiver enable; cycle end decides
  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (readReq) next_state = READ_CYC;
        else if (writeReq) next_state = WRITE_CYC;
      end
      READ_CYC, WRITE_CYC: begin
        if (endHit) next_state = IDLE;
      end
      default: next_state = IDLE;
    endcase
  end

  assign next_enabled = inCycle && !endHit && (enabled || startHit);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state        <= IDLE;
      enabled      <= 1'b0;
      latchedWrite <= 1'b0;
    end else begin
      state        <= next_state;
      enabled      <= next_enabled;
      latchedWrite <= (next_state == WRITE_CYC);
    end
  end

  // ----------------------------------------------------------------
  // enable decode
  // ----------------------------------------------------------------
  wire readActive  = next_enabled && (next_state == READ_CYC);
  wire writeActive = next_enabled && (next_state == WRITE_CYC);

  function automatic logic [3:0] lane_strobes(input logic [3:0] sel_n,
                                             input logic       act);
    // bit zero always maps to the least significant byte lane
    lane_strobes = act ? sel_n : LANES_IDLE;
  endfunction

  wire [3:0] next_laneStrobe_n = lane_strobes(cpuBus.byteLaneSelect_n,
                                              writeActive);
  wire next_readXcvr_n = !(inCycle && !endHit && readReq
                          && !cpuBus.cpuDataEnable_n);
  wire next_guarded_n  = !(next_enabled && !rawPeriphSelect_n);

  // transceiver and extended strobe outlast the lane strobe for hold
  logic writeXcvr_n;
  logic extWrite_n;

  hold_extend #(
    .EXT (XCVR_EXT_CLKS)
  ) u_xcvr_hold (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .level_n     (!writeActive),
    .stretched_n (writeXcvr_n)
  );

  hold_extend #(
    .EXT (WRITE_EXT_CLKS)
  ) u_write_hold (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .level_n     (!writeActive),
    .stretched_n (extWrite_n)
  );

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strobes         <= '1;
      periphReadWrite <= 1'b1;
    end else begin
      strobes.readOutputEnable_n    <= !readActive;
      strobes.readXcvrEnable_n      <= next_readXcvr_n;
      strobes.writeXcvrEnable_n     <= writeXcvr_n;
      strobes.writeLaneStrobe_n     <= next_laneStrobe_n;
      strobes.extWriteStrobe_n      <= extWrite_n;
      strobes.guardedPeriphSelect_n <= next_guarded_n;
      // read/write level held for the whole cycle
      periphReadWrite <= (next_state == WRITE_CYC) ? 1'b0 : 1'b1;
    end
  end

  reset_sync #(
    .STAGES (SYNC_STAGES)
  ) u_reset_sync (
    .sys_clk        (sys_clk),
    .powerOnReset_n (powerOnReset_n),
    .syncReset_n    (resetOut_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_end_seen;
    !cycleTiming.cycleEnd_n && inCycle;
  endsequence

  a_end_closes : assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_end_seen |=> strobes.readOutputEnable_n
      && strobes.writeLaneStrobe_n == LANES_IDLE
      && strobes.guardedPeriphSelect_n)
    else $error("strobe open after cycle end");

  a_no_early_open : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!enabled && cycleTiming.enableStart_n) |=> strobes.readOutputEnable_n
      && strobes.writeLaneStrobe_n == LANES_IDLE)
    else $error("enable opened without enable start");

  a_read_oe : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !strobes.readOutputEnable_n |-> $past(readReq || state == READ_CYC))
    else $error("read enable outside read cycle");

  a_lane_subset : assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((~strobes.writeLaneStrobe_n) & $past(cpuBus.byteLaneSelect_n))
      == 4'h0)
    else $error("unselected lane strobed");

  a_read_xcvr : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !strobes.readXcvrEnable_n |-> $past(!cpuBus.cpuDataEnable_n))
    else $error("read transceiver without cpu data enable");

  a_xcvr_hold : assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(strobes.writeLaneStrobe_n == LANES_IDLE) && latchedWrite == 1'b0
      |-> !strobes.writeXcvrEnable_n)
    else $error("write transceiver dropped with strobe");

  a_guard_gate : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !strobes.guardedPeriphSelect_n |-> $past(enabled || startHit))
    else $error("guarded select without enable start");

  a_idle_quiet : assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == IDLE && $past(state) == IDLE) |-> strobes.readOutputEnable_n
      && strobes.guardedPeriphSelect_n)
    else $error("enable active while idle");

  a_end_idle : assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_end_seen |=> state == IDLE)
    else $error("cycle end did not return to idle");

endmodule
`default_nettype wire

// ### rtl/mem_strobe_pkg.sv
// shared types and constants for the memory strobe enable logic
// assumes one system clock and active-low strobes on every pin
package mem_strobe_pkg;

  localparam int LANES          = 4;
  localparam int SYNC_STAGES    = 2;
  localparam int WRITE_EXT_CLKS = 1;
  localparam int XCVR_EXT_CLKS  = 2;
  localparam int SYS_CLK_MHZ    = 100;
  localparam int CLK_PERIOD_NS  = 1000 / SYS_CLK_MHZ;

  localparam logic [3:0] LANES_IDLE = 4'hF;

  // processor side strobes, all active low
  typedef struct packed {
    logic       readStrobe_n;
    logic       writeStrobe_n;
    logic [3:0] byteLaneSelect_n;
    logic       cpuDataEnable_n;
  } cpu_bus_t;

  // timing from the cycle controller, active low
  typedef struct packed {
    logic enableStart_n;
    logic cycleEnd_n;
  } cycle_timing_t;

  // generated enables, all active low
  typedef struct packed {
    logic       readOutputEnable_n;
    logic       readXcvrEnable_n;
    logic       writeXcvrEnable_n;
    logic [3:0] writeLaneStrobe_n;
    logic       extWriteStrobe_n;
    logic       guardedPeriphSelect_n;
  } strobe_out_t;

  typedef enum logic [1:0] {
    IDLE,
    READ_CYC,
    WRITE_CYC
  } cycle_state_t;

endpackage

// ### rtl/reset_sync.sv
// reset synchroniser for the board reset output
// assumes power-on reset is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module reset_sync #(
  parameter int STAGES = mem_strobe_pkg::SYNC_STAGES
) (
  input  wire logic sys_clk,
  input  wire logic powerOnReset_n,
  output var  logic syncReset_n
);
  import mem_strobe_pkg::*;

  initial begin
    if (STAGES < 2) $error("reset_sync needs at least two stages");
  end

  logic [STAGES-1:0] stage;
  logic [STAGES-1:0] warm;

  // only the last stage is looked at outside
  always_ff @(posedge sys_clk) begin
    stage <= {stage[STAGES-2:0], powerOnReset_n};
  end

  // unknown until the chain has filled; keeps the check quiet at start
  always_ff @(posedge sys_clk) begin
    warm <= {warm[STAGES-2:0], 1'b1};
  end

  assign syncReset_n = stage[STAGES-1];

  a_reset_follows : assert property (@(posedge sys_clk)
    warm[STAGES-1] |-> syncReset_n == $past(powerOnReset_n, STAGES))
    else $error("reset output not delayed copy of input");

endmodule
`default_nettype wire

// ### rtl/hold_extend.sv
// stretches an active-low level by a fixed number of clocks
// assumes a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module hold_extend #(
  parameter int EXT = 1
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic level_n,
  output var  logic stretched_n
);
  import mem_strobe_pkg::*;

  initial begin
    if (EXT < 1 || EXT > 7) $error("hold_extend EXT out of range");
  end

  logic [2:0] count;
  logic [2:0] next_count;

  assign next_count = !level_n ? 3'(EXT) :
                      (count != 3'h0) ? count - 3'h1 : 3'h0;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= 3'h0;
    end else begin
      count <= next_count;
    end
  end

  assign stretched_n = level_n && (count == 3'h0);

endmodule
`default_nettype wire

// ### dv/cpu_cycle_model.sv
// processor bus and cycle controller stand-in for the strobe logic
// assumes the bench calls its tasks from a process synced to sys_clk
`timescale 1ns/1ps
`default_nettype none
module cpu_cycle_model (
  input  wire logic                          sys_clk,
  output var  mem_strobe_pkg::cpu_bus_t      cpuBus,
  output var  mem_strobe_pkg::cycle_timing_t cycleTiming
);
  import mem_strobe_pkg::*;

  initial begin
    cpuBus = '{1'b1, 1'b1, 4'hF, 1'b1};
    cycleTiming = '{1'b1, 1'b1};
  end

  // ----------------------------------------
  // one bus cycle
  // ----------------------------------------
  // early drops the cpu strobe before cycle end, as the real edge may
  task automatic run_cycle(input logic rd, input logic [3:0] sel,
                           input int waits, input logic early);
    @(posedge sys_clk);
    cpuBus <= '{~rd, rd, sel, ~rd};
    @(posedge sys_clk);
    cycleTiming.enableStart_n <= 1'b0;
    @(posedge sys_clk);
    cycleTiming.enableStart_n <= 1'b1;
    if (early) begin
      cpuBus.readStrobe_n <= 1'b1;
      cpuBus.writeStrobe_n <= 1'b1;
    end
    repeat (waits) @(posedge sys_clk);
    cycleTiming.cycleEnd_n <= 1'b0;
    @(posedge sys_clk);
    cycleTiming.cycleEnd_n <= 1'b1;
    // released selects show the inverse, not the last value
    cpuBus <= '{1'b1, 1'b1, ~sel, 1'b1};
  endtask

  task automatic stray_start();
    @(posedge sys_clk);
    cycleTiming.enableStart_n <= 1'b0;
    @(posedge sys_clk);
    cycleTiming.enableStart_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### dv/test_memory_strobe_enable_logic.sv
// self-checking bench for the memory strobe enable logic
// assumes the partner model drives the cpu bus and cycle timing
`timescale 1ns/1ps
`default_nettype none
module test_memory_strobe_enable_logic;
  import mem_strobe_pkg::*;
  logic          sys_clk;
  logic          rst_n;
  logic          powerOnReset_n;
  logic          rawPeriphSelect_n;
  cpu_bus_t      cpuBus;
  cycle_timing_t cycleTiming;
  strobe_out_t   strobes;
  logic          periphReadWrite;
  logic          resetOut_n;
  int            fails = 0;
  int            n_tests = 0;
  int            cycles = 0;

  memory_strobe_enable_logic #(.LANE_COUNT(LANES)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .powerOnReset_n(powerOnReset_n),
    .cpuBus(cpuBus), .cycleTiming(cycleTiming),
    .rawPeriphSelect_n(rawPeriphSelect_n), .strobes(strobes),
    .periphReadWrite(periphReadWrite), .resetOut_n(resetOut_n));
  cpu_cycle_model model (
    .sys_clk(sys_clk), .cpuBus(cpuBus), .cycleTiming(cycleTiming));

  // ----------------------------------------
  // clock, timeout, compare
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp_out(input strobe_out_t got, input strobe_out_t exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // k counts edges after the one that launches the cpu strobe
  task automatic check_cycle(input logic rd, input logic [3:0] sel,
                             input int w, input logic early);
    strobe_out_t exp;
    logic        open;
    fork
      model.run_cycle(rd, sel, w, early);
      begin
        @(posedge sys_clk);
        for (int k = 1; k <= w + 6; k++) begin
          @(posedge sys_clk);
          #1;
          open = (k >= 2) && (k <= w + 2);
          exp.readOutputEnable_n = ~(rd & open);
          exp.readXcvrEnable_n = ~(rd & open);
          exp.writeXcvrEnable_n = ~(~rd & (k >= 2) & (k <= w + 4));
          exp.writeLaneStrobe_n = (~rd & open) ? sel : LANES_IDLE;
          exp.extWriteStrobe_n = ~(~rd & (k >= 2) & (k <= w + 3));
          exp.guardedPeriphSelect_n = ~(open & ~rawPeriphSelect_n);
          cmp_out(strobes, exp);
          if (k <= w + 2) cmp_bit(periphReadWrite, rd);
        end
      end
    join
  endtask

  task automatic sc_reset();
    cmp_out(strobes, '1);
    cmp_bit(periphReadWrite, 1'b1);
  endtask

  // byte, halfword, tri-byte, word and top byte, zero to four waits
  task automatic sc_lanes();
    logic [3:0] pats [5] = '{4'hE, 4'hC, 4'h8, 4'h0, 4'h7};
    for (int i = 0; i < 5; i++) check_cycle(1'b0, pats[i], i, 1'b0);
  endtask

  task automatic sc_read();
    @(posedge sys_clk);
    rawPeriphSelect_n <= 1'b0;
    check_cycle(1'b1, 4'h0, 2, 1'b0);
    @(posedge sys_clk);
    rawPeriphSelect_n <= 1'b1;
  endtask

  task automatic sc_idle();
    @(posedge sys_clk);
    rawPeriphSelect_n <= 1'b0;
    model.stray_start();
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      #1;
      cmp_out(strobes, '1);
    end
    @(posedge sys_clk);
    rawPeriphSelect_n <= 1'b1;
  endtask

  task automatic sc_por();
    @(posedge sys_clk);
    powerOnReset_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    cmp_bit(resetOut_n, 1'b1);
    @(posedge sys_clk);
    #1;
    cmp_bit(resetOut_n, 1'b0);
    @(posedge sys_clk);
    powerOnReset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    rst_n = 1'b0;
    powerOnReset_n = 1'b1;
    rawPeriphSelect_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    sc_reset();
    sc_lanes();
    sc_read();
    check_cycle(1'b0, 4'h3, 3, 1'b1);
    sc_idle();
    sc_por();
    end_sim();
  end
endmodule
`default_nettype wire
